// ### core/pq_qualifier.sv
// Event qualifier by logical processor and privilege level, one event counter,
// a shared time-stamp counter and an AXI4-Lite register slave.
// Assumes event and thread state come from core logic on aclk, unsynchronised.
//
// Operation
// - Thread identified by initial identifier bit 0
// - Events classed thread-specific or thread-independent
// - Specific events use only owning thread flags
// - Kernel flag at level 0, user otherwise
// - Independent events OR flags across threads
// - Independent: both levels count always, none never
// - Counting stops only when both threads halt
// - Non-halted ticks per selected logical processor
// - Non-sleep ticks per physical processor
// - Shared time-stamp counter stops in deep sleep
// - Counter overflow raises sampling interrupt
// - Selection flags at bits zero to three
// - Configuration enable bit twelve, cleared on reset
//
// The AXI4-Lite interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps

module pq_qualifier (
	// Clock and reset
	input  wire logic                      aclk,
	input  wire logic                      aresetn,
	// AXI4-Lite write address
	input  wire logic                      s_axi_awvalid,
	output logic                           s_axi_awready,
	input  wire logic [pq_pkg::ADDR_W-1:0] s_axi_awaddr,
	input  wire logic [2:0]                s_axi_awprot,
	// AXI4-Lite write data
	input  wire logic                      s_axi_wvalid,
	output logic                           s_axi_wready,
	input  wire logic [31:0]               s_axi_wdata,
	input  wire logic [3:0]                s_axi_wstrb,
	// AXI4-Lite write response
	output logic                           s_axi_bvalid,
	input  wire logic                      s_axi_bready,
	output logic [1:0]                     s_axi_bresp,
	// AXI4-Lite read address
	input  wire logic                      s_axi_arvalid,
	output logic                           s_axi_arready,
	input  wire logic [pq_pkg::ADDR_W-1:0] s_axi_araddr,
	input  wire logic [2:0]                s_axi_arprot,
	// AXI4-Lite read data
	output logic                           s_axi_rvalid,
	input  wire logic                      s_axi_rready,
	output logic [31:0]                    s_axi_rdata,
	output logic [1:0]                     s_axi_rresp,
	// Core state and events
	input  wire pq_pkg::pq_thread_t        thread_zero,
	input  wire pq_pkg::pq_thread_t        thread_one,
	input  wire pq_pkg::pq_phys_t          phys,
	input  wire pq_pkg::pq_event_t         core_event,
	// Status outputs
	output logic                           irq,
	output logic                           pmon_powered,
	output logic                           count_tick
);
	import pq_pkg::*;

	logic [31:0]       evsel_r;
	logic [31:0]       cfg_r;
	logic [31:0]       count_r;
	logic [63:0]       tsc_r;
	logic [IRQ_W-1:0]  irq_stat_r;
	logic [IRQ_W-1:0]  irq_mask_r;
	logic              aw_full_r;
	logic              w_full_r;
	logic [ADDR_W-1:0] aw_addr_r;
	logic [31:0]       w_data_r;
	logic [3:0]        w_strb_r;
	logic              bvalid_r;
	logic [1:0]        bresp_r;
	logic              rvalid_r;
	logic [31:0]       rdata_r;
	logic [1:0]        rresp_r;
	logic              powered_r;
	logic              tick_r;

	// Byte-lane merge for partial writes
	function automatic logic [31:0] pq_merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] strb);
		logic [31:0] res;
		res = old_v;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[8*i +: 8] = new_v[8*i +: 8];
			end
		end
		return res;
	endfunction

	// Write channel: address and data are held independently until both arrive
	logic wr_fire;
	logic rd_fire;
	assign s_axi_awready = !aw_full_r;
	assign s_axi_wready  = !w_full_r;
	assign wr_fire       = aw_full_r && w_full_r && !bvalid_r;
	assign s_axi_bvalid  = bvalid_r;
	assign s_axi_bresp   = bresp_r;
	assign s_axi_arready = !rvalid_r;
	assign rd_fire       = s_axi_arvalid && !rvalid_r;
	assign s_axi_rvalid  = rvalid_r;
	assign s_axi_rdata   = rdata_r;
	assign s_axi_rresp   = rresp_r;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_r <= 1'b0;
			aw_addr_r <= '0;
		end else if (s_axi_awvalid && !aw_full_r) begin
			aw_full_r <= 1'b1;
			aw_addr_r <= s_axi_awaddr;
		end else if (wr_fire) begin
			aw_full_r <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_full_r <= 1'b0;
			w_data_r <= '0;
			w_strb_r <= '0;
		end else if (s_axi_wvalid && !w_full_r) begin
			w_full_r <= 1'b1;
			w_data_r <= s_axi_wdata;
			w_strb_r <= s_axi_wstrb;
		end else if (wr_fire) begin
			w_full_r <= 1'b0;
		end
	end

	logic wr_mapped;
	always_comb begin
		case (aw_addr_r)
			OFF_EVSEL, OFF_CFG, OFF_COUNT, OFF_IRQ_MASK: wr_mapped = 1'b1;
			default:                                     wr_mapped = 1'b0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_r <= 1'b0;
			bresp_r  <= RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_r <= 1'b1;
			bresp_r  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_r <= 1'b0;
		end
	end

	logic evsel_wr;
	logic cfg_wr;
	logic cnt_wr;
	logic mask_wr;
	assign evsel_wr = wr_fire && (aw_addr_r == OFF_EVSEL);
	assign cfg_wr   = wr_fire && (aw_addr_r == OFF_CFG);
	assign cnt_wr   = wr_fire && (aw_addr_r == OFF_COUNT);
	assign mask_wr  = wr_fire && (aw_addr_r == OFF_IRQ_MASK);

	// Flags and mode select; unused bits stay zero
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			evsel_r <= EVSEL_RST;
		end else if (evsel_wr) begin
			evsel_r <= pq_merge(evsel_r, w_data_r, w_strb_r) & EVSEL_WMASK;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cfg_r <= CFG_RST;
		end else if (cfg_wr) begin
			cfg_r <= pq_merge(cfg_r, w_data_r, w_strb_r) & CFG_WMASK;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_mask_r <= IRQ_RST;
		end else if (mask_wr) begin
			// Only the low byte lane carries mask bits
			irq_mask_r <= w_strb_r[0] ? w_data_r[IRQ_W-1:0] : irq_mask_r;
		end
	end

	// Qualification, evaluated on this cycle's thread state
	logic     t0_krn;
	logic     thread_zero_user_qual;
	logic     t1_krn;
	logic     thread_one_user_qual;
	logic     own_is_one;
	logic     own_kernel;
	logic     own_krn_flag;
	logic     own_usr_flag;
	logic     ts_hit;
	logic     any_krn;
	logic     any_usr;
	logic     ti_hit;
	logic     ev_hit;
	pq_mode_t mode;
	assign t0_krn = evsel_r[EVSEL_T0_KRN];
	assign thread_zero_user_qual = evsel_r[EVSEL_THREAD_ZERO_USER_QUAL];
	assign t1_krn = evsel_r[EVSEL_T1_KRN];
	assign thread_one_user_qual = evsel_r[EVSEL_THREAD_ONE_USER_QUAL];
	assign mode   = pq_mode_t'(evsel_r[EVSEL_MODE_HI:EVSEL_MODE_LO]);

	assign own_is_one   = core_event.initial_id[0];
	assign own_kernel   = own_is_one ? (thread_one.current_privilege_level == CPL_KERNEL)
		: (thread_zero.current_privilege_level == CPL_KERNEL);
	assign own_krn_flag = own_is_one ? t1_krn : t0_krn;
	assign own_usr_flag = own_is_one ? thread_one_user_qual : thread_zero_user_qual;
	assign ts_hit       = own_kernel ? own_krn_flag : own_usr_flag;

	assign any_krn = t0_krn || t1_krn;
	assign any_usr = thread_zero_user_qual || thread_one_user_qual;
	assign ti_hit  = (any_krn && any_usr)
		|| (any_krn && (thread_zero.current_privilege_level == CPL_KERNEL || thread_one.current_privilege_level == CPL_KERNEL))
		|| (any_usr && (thread_zero.current_privilege_level != CPL_KERNEL || thread_one.current_privilege_level != CPL_KERNEL));

	assign ev_hit = core_event.valid && (core_event.independent ? ti_hit : ts_hit);

	// Counter powers down only once both threads halt
	logic powered;
	assign powered = !(thread_zero.halted && thread_one.halted);

	logic sel_thr_run;
	logic phys_awake;
	logic cond;
	assign sel_thr_run = evsel_r[EVSEL_TICK_THR]
		? !(thread_one.halted || thread_one.power_save)
		: !(thread_zero.halted || thread_zero.power_save);
	assign phys_awake  = !(phys.sleep || phys.power_save);

	always_comb begin
		case (mode)
			PQ_MODE_EVENT:    cond = ev_hit;
			PQ_MODE_NONHALT:  cond = sel_thr_run;
			PQ_MODE_NONSLEEP: cond = phys_awake;
			default:          cond = 1'b0;
		endcase
	end

	logic inc;
	logic cnt_ovf;
	assign inc     = cfg_r[CFG_ENABLE] && powered && cond;
	assign cnt_ovf = inc && !cnt_wr && (count_r == 32'hFFFFFFFF);

	// A software write takes precedence over an increment in the same cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			count_r <= COUNT_RST;
		end else if (cnt_wr) begin
			count_r <= pq_merge(count_r, w_data_r, w_strb_r);
		end else if (inc) begin
			count_r <= count_r + 32'h1;
		end
	end

	// Shared by both threads, so no per-thread copy exists
	logic tsc_wrap;
	assign tsc_wrap = !phys.deep_sleep && (tsc_r == 64'hFFFFFFFFFFFFFFFF);
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tsc_r <= TSC_RST;
		end else if (!phys.deep_sleep) begin
			tsc_r <= tsc_r + 64'h1;
		end
	end

	// Sticky status; a read clears it, but a same-cycle event survives
	logic             stat_rd;
	logic [IRQ_W-1:0] irq_set;
	assign stat_rd = rd_fire && (s_axi_araddr == OFF_IRQ_STAT);
	assign irq_set = {tsc_wrap, cnt_ovf};
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_stat_r <= IRQ_RST;
		end else begin
			irq_stat_r <= (stat_rd ? IRQ_RST : irq_stat_r) | irq_set;
		end
	end

	assign irq = |(irq_stat_r & irq_mask_r);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			powered_r <= 1'b1;
			tick_r    <= 1'b0;
		end else begin
			powered_r <= powered;
			tick_r    <= inc && !cnt_wr;
		end
	end

	assign pmon_powered = powered_r;
	assign count_tick   = tick_r;

	// Read channel: data registered on the same edge that takes the address
	logic [31:0] rd_val;
	logic        rd_ok;
	always_comb begin
		rd_ok = 1'b1;
		case (s_axi_araddr)
			OFF_EVSEL:    rd_val = evsel_r;
			OFF_CFG:      rd_val = cfg_r;
			OFF_COUNT:    rd_val = count_r;
			OFF_TSC_LO:   rd_val = tsc_r[31:0];
			OFF_TSC_HI:   rd_val = tsc_r[63:32];
			OFF_IRQ_STAT: rd_val = {30'h0, irq_stat_r};
			OFF_IRQ_MASK: rd_val = {30'h0, irq_mask_r};
			OFF_STATE:    rd_val = {26'h0, phys.deep_sleep, phys.sleep,
				thread_one.halted, thread_zero.halted, powered_r, irq};
			default: begin
				rd_val = 32'h0;
				rd_ok  = 1'b0;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_r <= 1'b0;
			rdata_r  <= 32'h0;
			rresp_r  <= RESP_OKAY;
		end else if (rd_fire) begin
			rvalid_r <= 1'b1;
			rdata_r  <= rd_val;
			rresp_r  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rready) begin
			rvalid_r <= 1'b0;
		end
	end

	// Checks on the qualification and counting paths
	AST_ID_BIT0: assert property (@(posedge aclk) disable iff (!aresetn)
		(core_event.valid && !core_event.independent && core_event.initial_id[0]
		&& !t1_krn && !thread_one_user_qual) |-> !ev_hit)
		else $error("thread one event counted with its flags clear");

	AST_CLASS_TI: assert property (@(posedge aclk) disable iff (!aresetn)
		(core_event.valid && core_event.independent && t0_krn && !thread_zero_user_qual && !t1_krn
		&& !thread_one_user_qual && thread_one.current_privilege_level == CPL_KERNEL) |-> ev_hit)
		else $error("independent event not counted on other thread kernel level");

	AST_TS_ISOLATE: assert property (@(posedge aclk) disable iff (!aresetn)
		(core_event.valid && !core_event.independent && !core_event.initial_id[0]
		&& !t0_krn && !thread_zero_user_qual) |-> !ev_hit)
		else $error("thread one flags leaked into thread zero event");

	AST_TS_PRIV: assert property (@(posedge aclk) disable iff (!aresetn)
		(core_event.valid && !core_event.independent && !core_event.initial_id[0]
		&& thread_zero.current_privilege_level == CPL_KERNEL) |-> (ev_hit == t0_krn))
		else $error("kernel level qualification wrong for thread zero");

	AST_TI_USER: assert property (@(posedge aclk) disable iff (!aresetn)
		(core_event.valid && core_event.independent && (thread_zero_user_qual || thread_one_user_qual)
		&& thread_zero.current_privilege_level != CPL_KERNEL) |-> ev_hit)
		else $error("independent user level event not counted");

	AST_TI_NONE: assert property (@(posedge aclk) disable iff (!aresetn)
		(core_event.independent && evsel_r[3:0] == 4'h0) |-> !ev_hit)
		else $error("independent event counted with all flags clear");

	AST_POWER: assert property (@(posedge aclk) disable iff (!aresetn)
		(thread_zero.halted && thread_one.halted && !cnt_wr) |=> $stable(count_r))
		else $error("counter moved with both threads halted");

	AST_NONHALT: assert property (@(posedge aclk) disable iff (!aresetn)
		(mode == PQ_MODE_NONHALT && cfg_r[CFG_ENABLE] && powered && sel_thr_run
		&& !cnt_wr) |=> count_r == $past(count_r) + 32'h1)
		else $error("non-halted tick missed");

	AST_NONSLEEP: assert property (@(posedge aclk) disable iff (!aresetn)
		(mode == PQ_MODE_NONSLEEP && cfg_r[CFG_ENABLE] && !phys_awake && !cnt_wr)
		|=> $stable(count_r))
		else $error("non-sleep tick counted while asleep");

	AST_TSC: assert property (@(posedge aclk) disable iff (!aresetn)
		phys.deep_sleep |=> tsc_r == $past(tsc_r))
		else $error("time-stamp moved in deep sleep");

	AST_OVF_IRQ: assert property (@(posedge aclk) disable iff (!aresetn)
		(cnt_ovf && irq_mask_r[IRQ_OVF] && !mask_wr) |=> (irq && count_r == 32'h0))
		else $error("overflow did not raise interrupt");

	AST_ENABLE: assert property (@(posedge aclk) disable iff (!aresetn)
		(!cfg_r[CFG_ENABLE] && !cnt_wr) |=> $stable(count_r))
		else $error("counter moved while disabled");

endmodule // pq_qualifier

// ### inc/pq_pkg.sv
// Constants and carrier types for the thread/privilege event qualifier.
// Assumes a 32-bit AXI4-Lite register bus and one core clock domain.
package pq_pkg;

	// Register byte offsets
	localparam int unsigned ADDR_W         = 5;
	localparam logic [4:0]  OFF_EVSEL      = 5'h00;
	localparam logic [4:0]  OFF_CFG        = 5'h04;
	localparam logic [4:0]  OFF_COUNT      = 5'h08;
	localparam logic [4:0]  OFF_TSC_LO     = 5'h0C;
	localparam logic [4:0]  OFF_TSC_HI     = 5'h10;
	localparam logic [4:0]  OFF_IRQ_STAT   = 5'h14;
	localparam logic [4:0]  OFF_IRQ_MASK   = 5'h18;
	localparam logic [4:0]  OFF_STATE      = 5'h1C;

	// Event selection fields
	localparam int unsigned EVSEL_THREAD_ONE_USER_QUAL   = 0;
	localparam int unsigned EVSEL_T1_KRN   = 1;
	localparam int unsigned EVSEL_THREAD_ZERO_USER_QUAL   = 2;
	localparam int unsigned EVSEL_T0_KRN   = 3;
	localparam int unsigned EVSEL_MODE_LO  = 4;
	localparam int unsigned EVSEL_MODE_HI  = 5;
	localparam int unsigned EVSEL_TICK_THR = 6;
	localparam logic [31:0] EVSEL_WMASK    = 32'h0000007F;

	// Counter configuration fields
	localparam int unsigned CFG_ENABLE     = 12;
	localparam logic [31:0] CFG_WMASK      = 32'h00001000;

	// Interrupt status / mask bits
	localparam int unsigned IRQ_OVF        = 0;
	localparam int unsigned IRQ_TSC_WRAP   = 1;
	localparam int unsigned IRQ_W          = 2;

	// Reset values
	localparam logic [31:0] EVSEL_RST      = 32'h00000000;
	localparam logic [31:0] CFG_RST        = 32'h00000000;
	localparam logic [31:0] COUNT_RST      = 32'h00000000;
	localparam logic [63:0] TSC_RST        = 64'h0000000000000000;
	localparam logic [1:0]  IRQ_RST        = 2'h0;

	// Privilege level zero is kernel level
	localparam logic [1:0]  CPL_KERNEL     = 2'h0;

	// AXI responses
	localparam logic [1:0]  RESP_OKAY      = 2'h0;
	localparam logic [1:0]  RESP_SLVERR    = 2'h2;

	typedef enum logic [1:0] {
		PQ_MODE_EVENT,
		PQ_MODE_NONHALT,
		PQ_MODE_NONSLEEP,
		PQ_MODE_OFF
	} pq_mode_t;

	// Per-thread state from the core
	typedef struct packed {
		logic [1:0] current_privilege_level;
		logic       halted;
		logic       power_save;
	} pq_thread_t;

	// Physical package state
	typedef struct packed {
		logic sleep;
		logic power_save;
		logic deep_sleep;
	} pq_phys_t;

	// One event occurrence per cycle
	typedef struct packed {
		logic       valid;
		logic       independent;
		logic [7:0] initial_id;
	} pq_event_t;

endpackage

// ### test/pq_core_model.sv
// Core-side model: two threads, package state and one event stream per cycle.
// Assumes run is changed by the bench just after a rising edge.
`timescale 1ns/100ps

module pq_core_model
	import pq_pkg::*;
(
	// Clock and control
	input  wire logic          aclk,
	input  wire logic          run,
	// Core state and events
	output pq_pkg::pq_thread_t thread_zero,
	output pq_pkg::pq_thread_t thread_one,
	output pq_pkg::pq_phys_t   phys,
	output pq_pkg::pq_event_t  core_event
);
	// One chance in four
	function automatic logic rare();
		return ($urandom % 4) == 0;
	endfunction

	// Stopped: both halted and deep sleep, privilege still moving
	function automatic pq_thread_t thr();
		return {2'($urandom), !run || rare(), rare()};
	endfunction

	initial begin
		thread_zero = 4'h2;
		thread_one  = 4'h2;
		phys        = 3'h1;
		core_event  = 10'h000;
	end

	// Upper identifier bits random, so only bit 0 may name the thread
	always @(posedge aclk) begin
		thread_zero <= thr();
		thread_one  <= thr();
		phys        <= {rare(), rare(), !run || rare()};
		core_event  <= {run && !rare(), 1'($urandom), 8'($urandom)};
	end

endmodule // pq_core_model

// ### test/pq_qualifier_bench.sv
// Self-checking bench for the event qualifier and its register slave.
// Assumes the core model stops all counting while registers are touched.
`timescale 1ns/100ps

module pq_qualifier_bench
	import pq_pkg::*;
;
	localparam int CYC_LIMIT = 8000;

	logic        aclk, aresetn, run, live;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, irq, pmon_powered, count_tick;
	logic [4:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, evsel_s, cnt_e;
	logic [1:0]  bresp, rresp;
	logic        en_s, ovf_e, tick_e, pw_e;
	logic [63:0] tsc_e;
	logic [33:0] rq[$];
	logic [1:0]  wq[$];
	pq_thread_t  t0, t1;
	pq_phys_t    ph;
	pq_event_t   ev;
	int          fails, n_tests, cyc;

	pq_qualifier pq_qualifier_inst (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
		.s_axi_awprot(3'h0), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .thread_zero(t0), .thread_one(t1), .phys(ph),
		.core_event(ev), .irq(irq), .pmon_powered(pmon_powered),
		.count_tick(count_tick)
	);

	pq_core_model pq_core_model_inst (
		.aclk(aclk), .run(run), .thread_zero(t0), .thread_one(t1),
		.phys(ph), .core_event(ev)
	);

	always #50 aclk = ~aclk;

	// Increment expected from this edge's core inputs
	function automatic logic qual();
		logic sel, k, u, hit;
		sel = ev.initial_id[0];
		k = ev.independent ? (evsel_s[1] | evsel_s[3]) : (sel ? evsel_s[1] : evsel_s[3]);
		u = ev.independent ? (evsel_s[0] | evsel_s[2]) : (sel ? evsel_s[0] : evsel_s[2]);
		if (ev.independent)
			hit = (k && u) || (k && (t0.current_privilege_level == CPL_KERNEL || t1.current_privilege_level == CPL_KERNEL))
				|| (u && (t0.current_privilege_level != CPL_KERNEL || t1.current_privilege_level != CPL_KERNEL));
		else
			hit = ((sel ? t1.current_privilege_level : t0.current_privilege_level) == CPL_KERNEL) ? k : u;
		case (evsel_s[5:4])
			2'h0: hit = ev.valid && hit;
			2'h1: hit = evsel_s[6] ? !(t1.halted || t1.power_save) : !(t0.halted || t0.power_save);
			2'h2: hit = !(ph.sleep || ph.power_save);
			default: hit = 1'b0;
		endcase
		return en_s && !(t0.halted && t1.halted) && hit;
	endfunction

	always @(posedge aclk) begin
		if (!aresetn) begin
			tick_e <= 1'b0;
			pw_e <= 1'b1;
			tsc_e <= 64'h0;
			ovf_e <= 1'b0;
			cnt_e <= 32'h0;
		end else begin
			tick_e <= qual();
			pw_e <= !(t0.halted && t1.halted);
			if (!ph.deep_sleep)
				tsc_e <= tsc_e + 64'h1;
			if (qual()) begin
				cnt_e <= cnt_e + 32'h1;
				if (cnt_e == 32'hFFFFFFFF)
					ovf_e <= 1'b1;
			end
		end
	end

	task automatic note(input logic ok, input string what);
		n_tests++;
		if (!ok) begin
			fails++;
			$display("unexpected at %0t: %s", $time, what);
		end
	endtask

	task automatic chk_bit(input logic got, input logic exp, input string what);
		note(got === exp, what);
	endtask

	task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
		note(got === exp, $sformatf("write resp %h, want %h", got, exp));
	endtask

	task automatic chk_read(input logic [33:0] got, input logic [33:0] exp);
		note(got === exp, $sformatf("read %h, want %h", got, exp));
	endtask

	task automatic stop_test();
		$display("Comparisons %0d, mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// Results watched where settled, halfway through the cycle
	always @(negedge aclk) begin
		if (live) begin
			chk_bit(count_tick, tick_e, "count tick");
			chk_bit(pmon_powered, pw_e, "counters powered");
		end
		if (bvalid && bready)
			chk_resp(bresp, wq.pop_front());
		if (rvalid && rready)
			chk_read({rdata, rresp}, rq.pop_front());
		cyc++;
		if (cyc > CYC_LIMIT) begin
			fails++;
			stop_test();
		end
	end

	task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] r);
		logic aw_t, w_t, b_t;
		wq.push_back(r);
		@(posedge aclk);
		awvalid <= 1'b1;
		awaddr <= a;
		wvalid <= 1'b1;
		wdata <= d;
		bready <= 1'b1;
		do begin
			@(negedge aclk);
			aw_t = awvalid && awready;
			w_t = wvalid && wready;
			b_t = bvalid;
			@(posedge aclk);
			if (aw_t)
				awvalid <= 1'b0;
			if (w_t)
				wvalid <= 1'b0;
		end while (!b_t);
		bready <= 1'b0;
		if (r == RESP_OKAY && a == OFF_EVSEL)
			evsel_s = d & EVSEL_WMASK;
		if (r == RESP_OKAY && a == OFF_CFG)
			en_s = d[CFG_ENABLE];
		if (r == RESP_OKAY && a == OFF_COUNT)
			cnt_e = d;
	endtask

	task automatic rd(input logic [4:0] a, input logic [31:0] d, input logic [1:0] r);
		logic r_t, ar_t;
		rq.push_back({d, r});
		if (a == OFF_IRQ_STAT)
			ovf_e = 1'b0;
		@(posedge aclk);
		arvalid <= 1'b1;
		araddr <= a;
		rready <= 1'b1;
		do begin
			@(negedge aclk);
			r_t = rvalid;
			ar_t = arvalid && arready;
			@(posedge aclk);
			if (ar_t)
				arvalid <= 1'b0;
		end while (!r_t);
		rready <= 1'b0;
	endtask

	// Let the core run, then quiet it so nothing moves during reads
	task automatic go(input int n);
		@(posedge aclk);
		run <= 1'b1;
		repeat (n) @(posedge aclk);
		run <= 1'b0;
		repeat (3) @(posedge aclk);
	endtask

	initial begin
		{aclk, aresetn, run, live, awvalid, wvalid, bready, arvalid, rready} = 9'h000;
		{awaddr, araddr, wdata, evsel_s, en_s} = 75'h0;
		{fails, n_tests, cyc} = 96'h0;
		void'($urandom(30));
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		live = 1'b1;
		rd(OFF_EVSEL, EVSEL_RST, RESP_OKAY);
		rd(OFF_CFG, CFG_RST, RESP_OKAY);
		rd(OFF_COUNT, COUNT_RST, RESP_OKAY);
		wr(OFF_EVSEL, 32'hFFFFFFFF, RESP_OKAY);
		rd(OFF_EVSEL, EVSEL_WMASK, RESP_OKAY);
		wr(OFF_CFG, 32'hFFFFFFFF, RESP_OKAY);
		rd(OFF_CFG, CFG_WMASK, RESP_OKAY);
		for (int i = 0; i < 22; i++) begin
			wr(OFF_EVSEL, {25'h0, 1'($urandom), i < 16 ? 2'h0 : 2'(i - 16), 4'(i)}, RESP_OKAY);
			wr(OFF_CFG, i != 5 ? 32'h00001000 : 32'h0, RESP_OKAY);
			wr(OFF_COUNT, $urandom, RESP_OKAY);
			go(40);
			rd(OFF_COUNT, cnt_e, RESP_OKAY);
		end
		wr(OFF_EVSEL, 32'h00000020, RESP_OKAY);
		wr(OFF_CFG, 32'h00001000, RESP_OKAY);
		wr(OFF_COUNT, 32'hFFFFFFF0, RESP_OKAY);
		go(200);
		rd(OFF_COUNT, cnt_e, RESP_OKAY);
		@(negedge aclk);
		chk_bit(irq, 1'b0, "irq while masked");
		wr(OFF_IRQ_MASK, 32'h00000001, RESP_OKAY);
		repeat (2) @(negedge aclk);
		chk_bit(irq, ovf_e, "irq on overflow");
		rd(OFF_IRQ_STAT, {31'h0, ovf_e}, RESP_OKAY);
		rd(OFF_IRQ_STAT, 32'h0, RESP_OKAY);
		repeat (2) @(negedge aclk);
		chk_bit(irq, 1'b0, "irq after clear");
		go(60);
		rd(OFF_TSC_LO, tsc_e[31:0], RESP_OKAY);
		rd(OFF_TSC_HI, tsc_e[63:32], RESP_OKAY);
		wr(OFF_TSC_LO, 32'h0, RESP_SLVERR);
		wr(OFF_IRQ_STAT, 32'h00000003, RESP_SLVERR);
		rd(OFF_TSC_LO, tsc_e[31:0], RESP_OKAY);
		stop_test();
	end

endmodule // pq_qualifier_bench
